// File: core/mscmd_map.vh
// Constants for the motor slave command handler.
// Assumes inclusion by the design modules; definitions only.
`ifndef MSCMD_MAP_VH
`define MSCMD_MAP_VH
`define MSCMD_OP_POSITION  6'h01
`define MSCMD_OP_POLL      6'h05
`define MSCMD_OP_UP        6'h08
`define MSCMD_OP_DOWN      6'h09
`define MSCMD_OP_STOP      6'h10
`define MSCMD_ADDR_MSB     7
`define MSCMD_ADDR_LSB     6
`define MSCMD_OP_MSB       5
`define MSCMD_ACK_CODE     8'h88
`define MSCMD_ERR_CODE     8'hff
`define MSCMD_FRAME_BYTES  3'h6
`define MSCMD_POLL_BYTES   3'h4
`define MSCMD_FIFO_DEPTH   8
`endif

// File: core/mscmd_fifo.v
// Small synchronous FIFO for transmit bytes.
// Assumes one clock, active-low async reset and a clock enable.
`timescale 1ns/10ps
module mscmd_fifo #(
    parameter WIDTH = 8,                 // Word width
    parameter DEPTH = 8,                 // Number of words
    parameter AW    = 3                  // Pointer width, log2 of DEPTH
) (
    input  wire             ref_clk,     // System clock
    input  wire             nrst,        // Async reset, active low
    input  wire             clk_en,      // Freezes state when low
    input  wire             in_valid,    // Write request
    output wire             in_ready,    // Room available
    input  wire [WIDTH-1:0] in_data,     // Write data
    output wire             out_valid,   // Data available
    input  wire             out_ready,   // Reader takes word
    output wire [WIDTH-1:0] out_data     // Head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];     // Storage
    reg [AW-1:0]    wr_ptr_reg;          // Write pointer
    reg [AW-1:0]    rd_ptr_reg;          // Read pointer
    reg [AW:0]      count_reg;           // Words held
    wire            do_wr;               // Write this cycle
    wire            do_rd;               // Read this cycle

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign do_wr     = clk_en & in_valid & in_ready;
    assign do_rd     = clk_en & out_valid & out_ready;

    // Storage write, no reset needed
    always @(posedge ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointer and count update
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd & ~do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: core/mscmd_handler.v
// Slave command handler for a servo node on a 9-bit multidrop serial line.
// Assumes a UART outside that delivers received bytes with ninth bit and
// error flags, and that accepts transmit bytes with a valid/ready pair.
// Overview of operation
// The node sits on a shared line with other slaves.
// In listen mode only command bytes are looked at.
// A command byte carries a two-bit node address
// and a six-bit operation code below it.
// A command for another node is dropped silently.
// In listen mode a command for this node is always echoed back.
// A position command switches to data mode, where
// the next six plain bytes are collected in order.
// After the sixth byte the frame is judged as one:
// any framing or overrun error on any byte of it
// stops the motor and answers with the error code.
// A clean frame loads the target and the velocity
// limit, answers with the acknowledge code, and
// arms the closed loop for the next control tick.
// A poll takes a snapshot of the measured position
// and queues its four bytes behind the echo.
// Manual up and down run at a fixed drive until a
// stop command or the travel limit ends them.
// All replies pass through one transmit FIFO.
// While a reply is still being queued, new receive
// events are not taken; the master must space them.
//
`timescale 1ns/10ps
`include "mscmd_map.vh"
module mscmd_handler #(
    parameter [1:0] NODE_ADDR   = 2'h0,     // This node's motor address
    parameter [7:0] MANUAL_DRIVE = 8'hff    // Constant drive in manual mode
) (
    input  wire        ref_clk,            // 200 MHz system clock
    input  wire        nrst,               // Async reset, active low
    input  wire        clk_en,             // Freezes all state when low
    input  wire        rx_event,           // Receive event pulse from UART
    input  wire        receive_done_flag,  // UART says a byte is complete
    input  wire [8:0]  rx_byte,            // Received byte, bit 8 is ninth bit
    input  wire        rx_frame_err,       // Framing error on this byte
    input  wire        rx_overrun_err,     // Overrun error on this byte
    output wire [7:0]  tx_data,            // Byte to transmit
    output wire        tx_valid,           // Transmit byte offered
    input  wire        transmit_done_flag, // UART took the offered byte
    input  wire        ctrl_tick,          // Control loop tick pulse
    input  wire [31:0] cur_position,       // Measured position
    input  wire        limit_hit,          // Travel limit reached
    output reg         data_mode,          // Receiver in data-receive mode
    output reg  [31:0] target_position,    // Target position register
    output reg  [15:0] max_velocity,       // Maximum velocity register
    output reg         manual_flag,        // Manual motion active
    output reg         motor_dir,          // 1 clockwise/up, 0 down
    output reg         motor_on,           // Drive enabled
    output reg  [7:0]  drive_load,         // Constant drive loaded each tick of manual motion
    output reg         drive_load_strobe,  // Pulse with drive_load
    output reg         use_profile,        // 1 profile control, 0 position PID
    output reg         closed_loop_start,  // Pulse: closed loop runs this tick
    output reg         rx_error,           // Pulse: event without done flag
    output wire        tx_busy             // Response still being sent
);
    // The queue entry is chosen from three sources.
    // Only one byte enters the FIFO per cycle, so the
    // sources are held as pending flags and drained in
    // a fixed order. The order keeps the echo ahead of
    // any reply or poll byte, which the master relies
    // on to tell which node is talking.
    // Queue entry request, combinational into the FIFO
    reg        q_valid;                    // Byte to queue
    reg  [7:0] q_data;                     // Byte value
    wire       q_ready;                    // FIFO has room

    // Receive-side state
    reg  [7:0] frame_reg [0:5];            // Position frame buffer
    reg  [2:0] rx_count_reg;               // Data bytes received
    reg        frame_bad_reg;              // Error seen during frame
    reg        auto_pending_reg;           // Start closed loop on next tick
    reg  [31:0] poll_snap_reg;             // Position snapshot for poll
    reg  [2:0] poll_left_reg;              // Poll bytes still to queue
    reg  [7:0] reply_reg;                  // Pending reply code
    reg        reply_pend_reg;             // Reply waiting for queue room
    reg  [8:0] rx_hold_reg;                // Command byte held for the echo
    reg        echo_pend_reg;              // Echo waiting for queue room

    wire        rx_err   = rx_frame_err | rx_overrun_err;
    wire [1:0]  cmd_addr = rx_byte[`MSCMD_ADDR_MSB:`MSCMD_ADDR_LSB];
    wire [5:0]  cmd_op   = rx_byte[`MSCMD_OP_MSB:0];
    // Busy queue: stall new reception processing while anything waits
    wire        q_busy   = echo_pend_reg | reply_pend_reg | (poll_left_reg != 3'h0);
    // An accepted receive event, for any address
    wire        ev_ok    = clk_en & rx_event & receive_done_flag & ~q_busy;
    wire        is_cmd   = rx_byte[8];
    wire        for_me   = (cmd_addr == NODE_ADDR);

    // The poll counter runs from four down to one.
    // Its value picks which byte of the snapshot goes
    // next, so the lowest byte leaves first and the
    // highest last. A snapshot is used so that motion
    // during the reply cannot tear the value.
    // Picks the poll byte, least significant first
    function [7:0] pos_byte;
        input [31:0] pos;
        input [2:0]  left;
        begin
            case (left)
                3'h4:    pos_byte = pos[7:0];
                3'h3:    pos_byte = pos[15:8];
                3'h2:    pos_byte = pos[23:16];
                default: pos_byte = pos[31:24];
            endcase
        end
    endfunction

    // Queue source selection: echo first, then reply, then poll bytes
    always @* begin
        q_valid = 1'b0;
        q_data  = 8'h00;
        if (echo_pend_reg) begin
            q_valid = 1'b1;
            q_data  = rx_hold_reg[7:0];
        end else if (reply_pend_reg) begin
            q_valid = 1'b1;
            q_data  = reply_reg;
        end else if (poll_left_reg != 3'h0) begin
            q_valid = 1'b1;
            q_data  = pos_byte(poll_snap_reg, poll_left_reg);
        end
    end

    // The main process handles every receive event,
    // the frame completion, the travel limit and the
    // control tick. Strobes are cleared at the top and
    // set again below only for one cycle.
    // Later assignments in the process win over
    // earlier ones, so the limit stop overrides a
    // manual command that arrives in the same cycle while manual motion is already active.
    // Nothing moves while the clock enable is low;
    // a strobe that is high at that time stays high
    // until the enable returns.
    // Main receive and control process
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_mode         <= 1'b0;
            target_position   <= 32'h00000000;
            max_velocity      <= 16'h0000;
            manual_flag       <= 1'b0;
            motor_dir         <= 1'b0;
            motor_on          <= 1'b0;
            drive_load        <= 8'h00;
            drive_load_strobe <= 1'b0;
            use_profile       <= 1'b0;
            closed_loop_start <= 1'b0;
            rx_error          <= 1'b0;
            rx_count_reg      <= 3'h0;
            frame_bad_reg     <= 1'b0;
            auto_pending_reg  <= 1'b0;
            poll_snap_reg     <= 32'h00000000;
            poll_left_reg     <= 3'h0;
            reply_reg         <= 8'h00;
            reply_pend_reg    <= 1'b0;
            rx_hold_reg       <= 9'h000;
            echo_pend_reg     <= 1'b0;
        end else if (clk_en) begin
            drive_load_strobe <= 1'b0;
            closed_loop_start <= 1'b0;
            rx_error          <= 1'b0;

            // Drain queue requests as the FIFO accepts them
            if (q_valid & q_ready) begin
                if (echo_pend_reg) begin
                    echo_pend_reg <= 1'b0;
                end else if (reply_pend_reg) begin
                    reply_pend_reg <= 1'b0;
                end else begin
                    poll_left_reg <= poll_left_reg - 3'h1;
                end
            end

            // Event without a completed byte is an error, nothing else
            if (rx_event & ~receive_done_flag) begin
                rx_error <= 1'b1;
            end

            if (ev_ok) begin
                if (!data_mode) begin
                    // Listen mode: only ninth-bit-set bytes count
                    if (is_cmd & for_me) begin
                        rx_hold_reg   <= rx_byte;
                        echo_pend_reg <= 1'b1;
                        case (cmd_op)
                            `MSCMD_OP_POSITION: begin
                                data_mode     <= 1'b1;
                                rx_count_reg  <= 3'h0;
                                frame_bad_reg <= 1'b0;
                            end
                            `MSCMD_OP_POLL: begin
                                poll_snap_reg <= cur_position;
                                poll_left_reg <= `MSCMD_POLL_BYTES;
                            end
                            `MSCMD_OP_UP: begin
                                manual_flag <= 1'b1;
                                motor_dir   <= 1'b1;
                                motor_on    <= 1'b1;
                            end
                            `MSCMD_OP_DOWN: begin
                                manual_flag <= 1'b1;
                                motor_dir   <= 1'b0;
                                motor_on    <= 1'b1;
                            end
                            `MSCMD_OP_STOP: begin
                                manual_flag      <= 1'b0;
                                target_position  <= cur_position;
                                auto_pending_reg <= 1'b1;
                            end
                            default: begin
                                echo_pend_reg <= 1'b1;
                            end
                        endcase
                    end
                end else if (!is_cmd) begin
                    // Data mode: collect the position frame
                    frame_reg[rx_count_reg] <= rx_byte[7:0];
                    if (rx_err) begin
                        frame_bad_reg <= 1'b1;
                    end
                    rx_count_reg <= rx_count_reg + 3'h1;
                end
            end

            // The frame is judged one cycle after its last
            // byte has been counted. Waiting that cycle lets
            // the last byte land in the buffer first, so the
            // registers take the full frame in one step.
            // An error on any byte taints the whole frame;
            // the old target and velocity are then kept.
            // The reply code waits in its own register until
            // the queue has taken it.
            // Frame complete: load registers or report error
            if (data_mode && rx_count_reg == `MSCMD_FRAME_BYTES) begin
                data_mode    <= 1'b0;
                rx_count_reg <= 3'h0;
                reply_pend_reg <= 1'b1;
                if (frame_bad_reg) begin
                    motor_on    <= 1'b0;
                    manual_flag <= 1'b0;
                    reply_reg   <= `MSCMD_ERR_CODE;
                end else begin
                    target_position <= {frame_reg[3], frame_reg[2],
                                        frame_reg[1], frame_reg[0]};
                    max_velocity    <= {frame_reg[5], frame_reg[4]};
                    use_profile     <= ({frame_reg[5], frame_reg[4]} != 16'h0000);
                    manual_flag      <= 1'b0;
                    motor_on         <= 1'b1;
                    auto_pending_reg <= 1'b1;
                    reply_reg        <= `MSCMD_ACK_CODE;
                end
            end

            // A travel limit during manual motion ends it at
            // once. The motor is switched off and the target
            // takes the measured position, so a later return
            // to closed loop does not pull the motor back.
            // The limit has no effect outside manual motion.
            // Manual stop at travel limit
            if (manual_flag & limit_hit) begin
                manual_flag      <= 1'b0;
                motor_on         <= 1'b0;
                target_position  <= cur_position;
            end

            // On a control tick, manual motion loads the
            // fixed drive value. Otherwise a pending start
            // from an acknowledged frame or a stop command
            // is released to the closed loop here, once.
            // Control tick actions
            if (ctrl_tick) begin
                if (manual_flag & ~limit_hit) begin
                    drive_load        <= MANUAL_DRIVE;
                    drive_load_strobe <= 1'b1;
                end else if (auto_pending_reg) begin
                    closed_loop_start <= 1'b1;
                    auto_pending_reg  <= 1'b0;
                end
            end
        end
    end

    // The FIFO decouples the handler from the line.
    // The longest burst is an echo followed by four
    // poll bytes, so eight words never overflow while
    // the queue flags stall new events. The UART pops
    // a word with its done flag; the head word stays
    // offered until then.
    // Transmit buffer between handler and UART
    mscmd_fifo #(
        .WIDTH (8),
        .DEPTH (`MSCMD_FIFO_DEPTH),
        .AW    (3)
    ) u_txq (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .in_valid  (q_valid),
        .in_ready  (q_ready),
        .in_data   (q_data),
        .out_valid (tx_valid),
        .out_ready (transmit_done_flag),
        .out_data  (tx_data)
    );

    // Busy covers both bytes still to queue and bytes
    // still held in the FIFO, so a caller can wait for
    // the whole response to leave.
    assign tx_busy = tx_valid | q_busy;
endmodule

// File: testbench/mscmd_handler_assertions.sv
// Concurrent checks on the motor slave command handler ports.
// Assumes the handler header constants and one clock domain.
`timescale 1ns/10ps
`include "mscmd_map.vh"
module mscmd_handler_chk #(
    parameter [1:0] NODE_ADDR    = 2'h0, // Node address under test
    parameter [7:0] MANUAL_DRIVE = 8'hff // Manual drive constant
) (
    input wire        ref_clk,            // System clock
    input wire        nrst,               // Async reset, active low
    input wire        clk_en,             // Clock enable
    input wire        rx_event,           // Receive event
    input wire        receive_done_flag,  // Byte complete
    input wire [8:0]  rx_byte,            // Received byte
    input wire [7:0]  tx_data,            // Transmit head
    input wire        tx_valid,           // Transmit offered
    input wire        transmit_done_flag, // Transmit taken
    input wire        ctrl_tick,          // Control tick
    input wire        limit_hit,          // Travel limit
    input wire        data_mode,          // Data-receive mode
    input wire [15:0] max_velocity,       // Velocity register
    input wire        manual_flag,        // Manual motion
    input wire [7:0]  drive_load,         // Drive value
    input wire        drive_load_strobe,  // Drive strobe
    input wire        use_profile,        // Profile select
    input wire        closed_loop_start,  // Closed loop pulse
    input wire        rx_error,           // Error pulse
    input wire        tx_busy             // Response pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Qualified command byte for this node and its captured value
    wire take = clk_en && rx_event && receive_done_flag && !tx_busy && !tx_valid && !data_mode;
    wire mine = rx_byte[8] && rx_byte[7:6] == NODE_ADDR;
    wire pcmd = rx_event && receive_done_flag && rx_byte == {1'b1, NODE_ADDR, `MSCMD_OP_POSITION};
    reg  [7:0] cmd_reg;                   // Low byte of rx_byte from the previous cycle, any byte
    always @(posedge ref_clk) begin
        cmd_reg <= rx_byte[7:0];
    end
    a_listen_ignore: assert property (take && !rx_byte[8] |=> (!tx_valid && !data_mode) [*3])
        else $error("data byte acted on in listen mode");
    a_addr_mismatch: assert property (take && rx_byte[8] && !mine |=> !tx_valid [*4])
        else $error("foreign command answered");
    a_echo_cmd: assert property (take && mine |-> ##[2:3] (tx_valid && tx_data == cmd_reg))
        else $error("command not echoed");
    a_data_entry: assert property ($rose(data_mode) |-> $past(pcmd, 1) || $past(pcmd, 2))
        else $error("data mode without position command");
    a_err_nodone: assert property (clk_en && rx_event && !receive_done_flag && !tx_busy |=> rx_error)
        else $error("missing error pulse");
    a_manual_drive: assert property (clk_en && manual_flag && ctrl_tick && !limit_hit
        |-> ##[1:2] (drive_load_strobe && drive_load == MANUAL_DRIVE))
        else $error("manual drive not loaded");
    a_limit_stop: assert property (clk_en && manual_flag && limit_hit |-> ##[1:2] !manual_flag)
        else $error("manual motion past limit");
    a_profile_sel: assert property (closed_loop_start |-> use_profile == (max_velocity != 16'h0))
        else $error("wrong controller selected");
    a_tx_hold: assert property (tx_valid && !transmit_done_flag |=> tx_valid && $stable(tx_data))
        else $error("transmit byte lost");
endmodule
bind mscmd_handler mscmd_handler_chk #(.NODE_ADDR(NODE_ADDR), .MANUAL_DRIVE(MANUAL_DRIVE)) u_chk (.*);

// File: testbench/mscmd_master_model.sv
// Master side receiver: takes offered bytes, may stall, logs them.
// Assumes the same clock as the handler.
`timescale 1ns/10ps
module mscmd_master_model (
    input  wire       ref_clk,            // System clock
    input  wire       nrst,               // Async reset, active low
    input  wire       tx_valid,           // Byte offered
    input  wire [7:0] tx_data,            // Offered byte
    input  wire       stall,              // Hold off taking bytes
    output reg        transmit_done_flag  // Byte taken this cycle
);
    reg [7:0] got [0:31];                 // Bytes received in order
    integer   n_got;                      // Count of bytes received
    // Take one byte at a time, never two edges running
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            transmit_done_flag <= 1'b0;
            n_got <= 0;
        end else begin
            transmit_done_flag <= tx_valid && !stall && !transmit_done_flag;
            if (transmit_done_flag && tx_valid) begin
                got[n_got] <= tx_data;
                n_got <= n_got + 1;
            end
        end
    end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the motor slave command handler.
// Assumes the master model and the checker are compiled alongside.
`timescale 1ns/10ps
`include "mscmd_map.vh"
module tb;
    localparam [1:0] NA = 2'h2;           // Node address under test
    reg ref_clk = 0, nrst = 0, clk_en = 1, rx_event = 0, receive_done_flag = 0;
    reg rx_frame_err = 0, rx_overrun_err = 0, ctrl_tick = 0, limit_hit = 0, stall = 0;
    reg [8:0] rx_byte = 9'h0;             // Byte from the line
    reg [31:0] cur_position = 32'h0;      // Measured position
    wire [7:0] tx_data, drive_load;
    wire tx_valid, transmit_done_flag, data_mode, manual_flag, motor_dir, motor_on;
    wire drive_load_strobe, use_profile, closed_loop_start, rx_error, tx_busy;
    wire [31:0] target_position;
    wire [15:0] max_velocity;
    integer n_mismatch = 0, num_checks = 0, tx_idx = 0;
    integer n_rxerr = 0, n_cls = 0, n_drv = 0; // Output pulses seen
    // Count one-cycle output pulses so tasks can judge them later
    always @(posedge ref_clk) begin
        if (rx_error === 1'b1) n_rxerr <= n_rxerr + 1;
        if (closed_loop_start === 1'b1) n_cls <= n_cls + 1;
        if (drive_load_strobe === 1'b1) n_drv <= n_drv + 1;
    end
    mscmd_handler #(.NODE_ADDR(NA)) uut (.*);
    mscmd_master_model m (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One received byte, then line spacing
    task rx(input [8:0] b, input dn, input fe, input oe);
        @(negedge ref_clk) {rx_event, receive_done_flag, rx_byte, rx_frame_err, rx_overrun_err} = {1'b1, dn, b, fe, oe};
        @(negedge ref_clk) {rx_event, receive_done_flag, rx_frame_err, rx_overrun_err} = 4'h0;
        repeat (4) @(negedge ref_clk);
    endtask
    task tick;
        @(negedge ref_clk) ctrl_tick = 1;
        @(negedge ref_clk) ctrl_tick = 0;
        repeat (3) @(negedge ref_clk);
    endtask
    // Next byte seen by the master
    task txb(input [7:0] e);
        integer k;
        for (k = 0; k < 400 && m.n_got <= tx_idx; k++) @(negedge ref_clk);
        if (m.n_got <= tx_idx) begin n_mismatch++; final_report; end
        chk("tx byte", e, m.got[tx_idx]);
        tx_idx++;
    endtask
    // Drain, then confirm no stray bytes
    task idle;
        integer k;
        for (k = 0; k < 400 && (tx_busy !== 1'b0 || tx_valid !== 1'b0); k++) @(negedge ref_clk);
        if (k == 400) begin n_mismatch++; final_report; end
        repeat (20) @(negedge ref_clk);
        chk("tx count", tx_idx, m.n_got);
    endtask
    task frame(input [31:0] p, input [15:0] v, input fe, input oe);
        integer i;
        rx({1'b1, NA, `MSCMD_OP_POSITION}, 1, 0, 0);
        for (i = 0; i < 4; i++) rx({1'b0, p[8*i+:8]}, 1, 0, 0);
        rx({1'b0, v[7:0]}, 1, 0, 0);
        rx({1'b0, v[15:8]}, 1, fe, oe);
    endtask
    task t_position;
        rx(9'h081, 1, 0, 0);
        frame(32'h12345678, 16'h0, 0, 0);
        txb({NA, `MSCMD_OP_POSITION});
        txb(`MSCMD_ACK_CODE);
        idle;
        chk("target", 32'h12345678, target_position);
        chk("max vel", 0, max_velocity);
        chk("data mode", 0, data_mode);
        chk("manual", 0, manual_flag);
        tick;
        chk("loop start", 1, n_cls);
        frame(32'h00000100, 16'h0302, 0, 0);
        txb({NA, `MSCMD_OP_POSITION});
        txb(`MSCMD_ACK_CODE);
        idle;
        chk("max vel", 16'h0302, max_velocity);
        tick;
        chk("loop start", 2, n_cls);
        chk("profile", 1, use_profile);
        $display("test position done");
    endtask
    task t_error;
        integer j;
        for (j = 0; j < 2; j++) begin
            frame(32'h0a0b0c0d, 16'h0102, j == 0, j == 1);
            txb({NA, `MSCMD_OP_POSITION});
            txb(`MSCMD_ERR_CODE);
            idle;
            chk("motor on", 0, motor_on);
        end
        $display("test error done");
    endtask
    task t_manual;
        cur_position = 32'h00abcdef;
        rx({1'b1, NA, `MSCMD_OP_UP}, 1, 0, 0);
        txb({NA, `MSCMD_OP_UP});
        chk("manual", 1, manual_flag);
        chk("dir", 1, motor_dir);
        tick;
        chk("drive strobe", 1, n_drv);
        chk("drive", 8'hff, drive_load);
        rx({1'b1, NA, `MSCMD_OP_DOWN}, 1, 0, 0);
        txb({NA, `MSCMD_OP_DOWN});
        chk("dir", 0, motor_dir);
        rx({1'b1, NA, `MSCMD_OP_STOP}, 1, 0, 0);
        txb({NA, `MSCMD_OP_STOP});
        chk("manual", 0, manual_flag);
        chk("target", 32'h00abcdef, target_position);
        rx({1'b1, NA, `MSCMD_OP_UP}, 1, 0, 0);
        txb({NA, `MSCMD_OP_UP});
        @(negedge ref_clk) limit_hit = 1;
        repeat (3) @(negedge ref_clk);
        chk("manual", 0, manual_flag);
        limit_hit = 0;
        idle;
        $display("test manual done");
    endtask
    task t_poll;
        stall = 1;
        cur_position = 32'hcafe0123;
        rx({1'b1, NA, `MSCMD_OP_POLL}, 1, 0, 0);
        repeat (10) @(negedge ref_clk);
        chk("tx valid", 1, tx_valid);
        stall = 0;
        txb({NA, `MSCMD_OP_POLL});
        txb(8'h23);
        txb(8'h01);
        txb(8'hfe);
        txb(8'hca);
        idle;
        $display("test poll done");
    endtask
    task t_reject;
        rx({1'b1, 2'h3, `MSCMD_OP_POLL}, 1, 0, 0);
        rx({1'b1, NA, `MSCMD_OP_POLL}, 0, 0, 0);
        idle;
        chk("rx error", 1, n_rxerr);
        clk_en = 0;
        rx({1'b1, NA, `MSCMD_OP_POLL}, 1, 0, 0);
        @(negedge ref_clk) clk_en = 1;
        idle;
        chk("frozen mode", 0, data_mode);
        $display("test reject done");
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        nrst = 1;
        repeat (2) @(negedge ref_clk);
        t_position;
        t_error;
        t_manual;
        t_poll;
        t_reject;
        final_report;
    end
endmodule
